/* lsbb_pkg.sv */
// Shared constants, encodings and types for the logic/shift/bit/branch unit
`default_nettype none
package lsbb_pkg;
	localparam int DATA_W = 8;
	localparam int PC_W = 15;
	localparam int INSTR_W = 14;
	localparam int ADDR_W = 7;
	localparam int OFS_W = 9;

	// Opcode fields, matched on the instruction's top bits
	localparam logic [5:0] OPC_AND_LIT = 6'h39;
	localparam logic [5:0] OPC_AND_REG = 6'h05;
	localparam logic [5:0] OPC_ASR = 6'h37;
	localparam logic [3:0] OPC_CLR_BIT = 4'h4;
	localparam logic [3:0] OPC_SET_BIT = 4'h5;
	localparam logic [4:0] OPC_PC_OFS = 5'h19;
	localparam logic [13:0] INSTR_PC_ACC = 14'h000B;

	// Field positions
	localparam int DEST_POS = 7;
	localparam int BIT_POS_LSB = 7;

	// Reset values
	localparam logic [PC_W-1:0] PC_RST = 15'h0000;
	localparam logic [DATA_W-1:0] ACC_RST = 8'h00;
	localparam logic DEST_ACC = 1'b0;

	typedef enum logic [2:0] {
		OP_NOP = 3'h0,
		OP_AND_LIT = 3'h1,
		OP_AND_REG = 3'h2,
		OP_ASR = 3'h3,
		OP_CLR = 3'h4,
		OP_SET = 3'h5,
		OP_JMP_K = 3'h6,
		OP_JMP_W = 3'h7
	} lsbb_op_t;

	typedef struct packed {
		lsbb_op_t op;
		logic dest;
		logic [ADDR_W-1:0] addr;
		logic [2:0] bitpos;
		logic [DATA_W-1:0] lit;
		logic [OFS_W-1:0] ofs;
	} lsbb_dec_t;

	// Split a raw instruction into its fields
	function automatic lsbb_dec_t lsbb_decode(input logic [INSTR_W-1:0] w);
		lsbb_dec_t d;
		d.op = OP_NOP;
		d.dest = w[DEST_POS];
		d.addr = w[ADDR_W-1:0];
		d.bitpos = w[BIT_POS_LSB+2:BIT_POS_LSB];
		d.lit = w[DATA_W-1:0];
		d.ofs = w[OFS_W-1:0];
		if (w[13:8] == OPC_AND_LIT)
			d.op = OP_AND_LIT;
		else if (w[13:8] == OPC_AND_REG)
			d.op = OP_AND_REG;
		else if (w[13:8] == OPC_ASR)
			d.op = OP_ASR;
		else if (w[13:10] == OPC_CLR_BIT)
			d.op = OP_CLR;
		else if (w[13:10] == OPC_SET_BIT)
			d.op = OP_SET;
		else if (w[13:9] == OPC_PC_OFS)
			d.op = OP_JMP_K;
		else if (w == INSTR_PC_ACC)
			d.op = OP_JMP_W;
		return d;
	endfunction : lsbb_decode
endpackage : lsbb_pkg
`default_nettype wire

/* lsbb_alu.sv */
// Data path: result, destination and flag effects of one operation
`default_nettype none
`timescale 1ns/1ns
module lsbb_alu (
	input wire lsbb_pkg::lsbb_op_t op,
	input wire logic dest,
	input wire logic [2:0] bitpos,
	input wire logic [lsbb_pkg::DATA_W-1:0] acc,
	input wire logic [lsbb_pkg::DATA_W-1:0] operand,
	output logic [lsbb_pkg::DATA_W-1:0] result,
	output logic to_acc,
	output logic to_reg,
	output logic zero_upd,
	output logic carry_upd,
	output logic carry
);
	// Operand is the literal or the register value read back
	always_comb
	begin
		result = operand;
		to_acc = 1'b0;
		to_reg = 1'b0;
		zero_upd = 1'b0;
		carry_upd = 1'b0;
		carry = operand[0];
		case (op)
			lsbb_pkg::OP_AND_LIT:
			begin
				result = acc & operand;
				to_acc = 1'b1;
				zero_upd = 1'b1;
			end
			lsbb_pkg::OP_AND_REG:
			begin
				result = acc & operand;
				to_acc = (dest == lsbb_pkg::DEST_ACC);
				to_reg = (dest != lsbb_pkg::DEST_ACC);
				zero_upd = 1'b1;
			end
			lsbb_pkg::OP_ASR:
			begin
				result = {operand[7], operand[7:1]};
				to_acc = (dest == lsbb_pkg::DEST_ACC);
				to_reg = (dest != lsbb_pkg::DEST_ACC);
				zero_upd = 1'b1;
				carry_upd = 1'b1;
			end
			lsbb_pkg::OP_CLR:
			begin
				result = operand & ~(8'h01 << bitpos);
				to_reg = 1'b1;
			end
			lsbb_pkg::OP_SET:
			begin
				result = operand | (8'h01 << bitpos);
				to_reg = 1'b1;
			end
			default:
			begin
				result = operand;
			end
		endcase
	end
endmodule : lsbb_alu
`default_nettype wire

/* lsbb_exec.sv */
// Execution unit for AND, arithmetic shift, bit set/clear and branches
`default_nettype none
`timescale 1ns/1ns
// Function
// - literal AND into accumulator, zero flag only
// - accumulator AND register, zero flag only
// - destination bit picks accumulator or register
// - arithmetic right shift, low bit to carry
// - shift result honours destination bit
// - clear one register bit, flags untouched
// - set one register bit, flags untouched
// - signed 9-bit offset jump, two cycles
// - unsigned accumulator offset jump, two cycles
// - jump second cycle executes as no-op
module lsbb_exec (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic [lsbb_pkg::INSTR_W-1:0] instr,
	input wire logic instr_valid,
	output logic instr_ready,
	output logic retire,
	output logic [lsbb_pkg::PC_W-1:0] pc,
	output logic [lsbb_pkg::DATA_W-1:0] acc,
	output logic zero_flag,
	output logic carry_flag,
	output logic [lsbb_pkg::ADDR_W-1:0] reg_addr,
	output logic reg_rd_en,
	input wire logic [lsbb_pkg::DATA_W-1:0] reg_rd_data,
	output logic reg_wr_en,
	output logic [lsbb_pkg::DATA_W-1:0] reg_wr_data
);
	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_READ = 4'b0010,
		ST_EXEC = 4'b0100,
		ST_NOP = 4'b1000
	} lsbb_state_t;

	lsbb_state_t state;
	lsbb_state_t next_state;
	lsbb_pkg::lsbb_dec_t dec;
	lsbb_pkg::lsbb_dec_t cur;
	logic accept;
	logic is_reg_op;
	logic is_jump;
	lsbb_pkg::lsbb_op_t alu_op;
	logic alu_dest;
	logic [2:0] alu_bit;
	logic [lsbb_pkg::DATA_W-1:0] alu_operand;
	logic [lsbb_pkg::DATA_W-1:0] alu_result;
	logic alu_to_acc;
	logic alu_to_reg;
	logic alu_zero_upd;
	logic alu_carry_upd;
	logic alu_carry;
	logic alu_apply;
	logic [lsbb_pkg::PC_W-1:0] pc_inc;
	logic [lsbb_pkg::PC_W-1:0] next_pc;
	logic [lsbb_pkg::PC_W-1:0] ofs_sext;
	logic [lsbb_pkg::PC_W-1:0] acc_ext;

	// Decode of the incoming word and the acceptance handshake
	assign dec = lsbb_pkg::lsbb_decode(instr);
	assign accept = instr_valid && instr_ready;
	assign is_reg_op = (dec.op == lsbb_pkg::OP_AND_REG) ||
		(dec.op == lsbb_pkg::OP_ASR) || (dec.op == lsbb_pkg::OP_CLR) ||
		(dec.op == lsbb_pkg::OP_SET);
	assign is_jump = (dec.op == lsbb_pkg::OP_JMP_K) ||
		(dec.op == lsbb_pkg::OP_JMP_W);

	// Literal ops run at acceptance, register ops once the read returns
	assign alu_op = (state == ST_EXEC) ? cur.op : dec.op;
	assign alu_dest = (state == ST_EXEC) ? cur.dest : dec.dest;
	assign alu_bit = (state == ST_EXEC) ? cur.bitpos : dec.bitpos;
	assign alu_operand = (state == ST_EXEC) ? reg_rd_data : dec.lit;
	assign alu_apply = (state == ST_EXEC) ||
		(accept && dec.op == lsbb_pkg::OP_AND_LIT);

	lsbb_alu u_alu (
		.op(alu_op),
		.dest(alu_dest),
		.bitpos(alu_bit),
		.acc(acc),
		.operand(alu_operand),
		.result(alu_result),
		.to_acc(alu_to_acc),
		.to_reg(alu_to_reg),
		.zero_upd(alu_zero_upd),
		.carry_upd(alu_carry_upd),
		.carry(alu_carry)
	);

	// Offsets widened to counter size before the add
	// Accumulator offset is unsigned, so it only ever jumps forward
	assign ofs_sext = {{(lsbb_pkg::PC_W - lsbb_pkg::OFS_W)
		{dec.ofs[lsbb_pkg::OFS_W-1]}}, dec.ofs};
	assign acc_ext = {{(lsbb_pkg::PC_W - lsbb_pkg::DATA_W){1'b0}},
		acc};

	// Fetch has already moved the counter on, so targets start at pc + 1
	// Targets wrap at the top of the counter, as the rules allow
	assign pc_inc = pc + 15'h0001;
	always_comb
	begin
		next_pc = pc_inc;
		case (dec.op)
			lsbb_pkg::OP_JMP_K:
				next_pc = pc_inc + ofs_sext;
			lsbb_pkg::OP_JMP_W:
				next_pc = pc_inc + acc_ext;
			default:
				next_pc = pc_inc;
		endcase
	end

	// Sequencing: one cycle for literals, three for register ops
	always_comb
	begin
		next_state = state;
		case (state)
			ST_IDLE:
				if (accept && is_reg_op)
					next_state = ST_READ;
				else if (accept && is_jump)
					next_state = ST_NOP;
			ST_READ:
				next_state = ST_EXEC;
			ST_EXEC:
				next_state = ST_IDLE;
			ST_NOP:
				next_state = ST_IDLE;
			default:
				next_state = ST_IDLE;
		endcase
	end

	// State and ready share one edge so ready is a clean flop
	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			state <= ST_IDLE;
			instr_ready <= 1'b1;
		end
		else
		begin
			state <= next_state;
			instr_ready <= (next_state == ST_IDLE);
		end
	end

	// Hold the decoded register op while the read is in flight
	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
			cur <= '0;
		else if (accept)
			cur <= dec;
	end

	// Program counter moves once per accepted instruction
	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
			pc <= lsbb_pkg::PC_RST;
		else if (accept)
			pc <= next_pc;
	end

	// Accumulator and flags; jumps and bit ops leave flags alone
	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			acc <= lsbb_pkg::ACC_RST;
			zero_flag <= 1'b0;
			carry_flag <= 1'b0;
		end
		else if (alu_apply)
		begin
			// A literal AND beside a pending write touches only acc and the zero flag
			if (alu_to_acc)
				acc <= alu_result;
			if (alu_zero_upd)
				zero_flag <= (alu_result == 8'h00);
			if (alu_carry_upd)
				carry_flag <= alu_carry;
		end
	end

	// Register file port: read one cycle, write back after exec
	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			reg_addr <= 7'h00;
			reg_rd_en <= 1'b0;
			reg_wr_en <= 1'b0;
			reg_wr_data <= 8'h00;
		end
		else
		begin
			reg_rd_en <= accept && is_reg_op;
			if (accept && is_reg_op)
				reg_addr <= dec.addr;
			// No write at all when the accumulator is the target
			reg_wr_en <= (state == ST_EXEC) && alu_to_reg;
			if (state == ST_EXEC)
				reg_wr_data <= alu_result;
		end
	end

	// Retire pulse marks the end of every instruction, no-op included
	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
			retire <= 1'b0;
		else
			retire <= (accept && !is_reg_op && !is_jump) ||
				(state == ST_EXEC) || (state == ST_NOP);
	end
endmodule : lsbb_exec
`default_nettype wire

/* lsbb_props.sv */
// Concurrent checks on the execution unit's ports
`timescale 1ns/1ns
`default_nettype none
module lsbb_props (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic [13:0] instr,
	input wire logic instr_valid,
	input wire logic instr_ready,
	input wire logic retire,
	input wire logic [14:0] pc,
	input wire logic [7:0] acc,
	input wire logic zero_flag,
	input wire logic carry_flag,
	input wire logic [6:0] reg_addr,
	input wire logic reg_rd_en,
	input wire logic [7:0] reg_rd_data,
	input wire logic reg_wr_en,
	input wire logic [7:0] reg_wr_data
);
	logic tk, jk, jw, asr, andr, bop;
	// Decoded view of the word taken at this edge
	assign tk = instr_valid && instr_ready;
	assign jk = tk && instr[13:9] == lsbb_pkg::OPC_PC_OFS;
	assign jw = tk && instr == lsbb_pkg::INSTR_PC_ACC;
	assign asr = tk && instr[13:8] == lsbb_pkg::OPC_ASR;
	assign andr = tk && instr[13:8] == lsbb_pkg::OPC_AND_REG;
	assign bop = tk && instr[13:11] == 3'b010; // Clear and set share 010
	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst);
	// Quiet slot: no file traffic, acc and flags frozen
	sequence s_idle;
		!reg_rd_en && !reg_wr_en && $stable(acc) && $stable(zero_flag)
			&& $stable(carry_flag);
	endsequence
	a_jump_noop_slot: assert property (jk || jw |=> !instr_ready ##0
		s_idle ##1 retire ##0 s_idle) else $error("jump slot");
	a_jump_lit_tgt: assert property (jk |=> pc == $past(pc) + 15'h0001
		+ {{6{$past(instr[8])}}, $past(instr[8:0])})
		else $error("offset jump pc");
	a_jump_acc_tgt: assert property (jw |=> pc == $past(pc) + 15'h0001
		+ {7'h00, $past(acc)}) else $error("acc jump pc");
	a_and_lit_acc: assert property (tk && instr[13:8] ==
		lsbb_pkg::OPC_AND_LIT |=> acc == ($past(acc) & $past(instr[7:0]))
		&& zero_flag == (acc == 8'h00) && $stable(carry_flag))
		else $error("and lit");
	a_reg_read_addr: assert property (asr || andr || bop |=>
		reg_rd_en && reg_addr == $past(instr[6:0]) ##2 retire)
		else $error("reg read");
	a_shift_to_acc: assert property (asr && !instr[7] |-> ##3
		acc == {$past(reg_rd_data[7]), $past(reg_rd_data[7:1])}
		&& carry_flag == $past(reg_rd_data[0])) else $error("shift");
	a_acc_dest_nowr: assert property ((asr || andr) && !instr[7]
		|-> ##1 !reg_wr_en [*3]) else $error("acc dest write");
	a_bit_ops_quiet: assert property (bop |=> ($stable(acc)
		&& $stable(zero_flag) && $stable(carry_flag)) [*3])
		else $error("bit op flags");
	a_dest_reg_wr: assert property ((asr || andr) && instr[7]
		|-> ##3 reg_wr_en && reg_addr == $past(instr[6:0], 3))
		else $error("reg dest write");
	a_set_bit_wr: assert property (bop && instr[10] |-> ##3
		reg_wr_en && reg_wr_data == ($past(reg_rd_data)
		| (8'h01 << $past(instr[9:7], 3))))
		else $error("set bit write");
	a_clr_bit_wr: assert property (bop && !instr[10] |-> ##3
		reg_wr_en && reg_wr_data == ($past(reg_rd_data)
		& ~(8'h01 << $past(instr[9:7], 3))))
		else $error("clear bit write");
endmodule : lsbb_props
`default_nettype wire

/* lsbb_regfile.sv */
// Behavioural data register file facing the unit
`timescale 1ns/1ns
`default_nettype none
module lsbb_regfile (
	input wire logic clock,
	input wire logic reg_rd_en,
	input wire logic [6:0] reg_addr,
	input wire logic reg_wr_en,
	input wire logic [7:0] reg_wr_data,
	output logic [7:0] reg_rd_data
);
	logic [7:0] mem [128];
	// Data valid only the cycle after a read; junk toggles otherwise
	always @(posedge clock)
	begin
		if (reg_wr_en)
			mem[reg_addr] <= reg_wr_data;
		reg_rd_data <= reg_rd_en ? mem[reg_addr] : ~reg_rd_data;
	end
endmodule : lsbb_regfile
`default_nettype wire

/* test_logic_shift_bit_branch_exec.sv */
// Self-checking bench for the logic/shift/bit/branch unit
`timescale 1ns/1ns
`default_nettype none
module test_logic_shift_bit_branch_exec;
	logic clock = 1'b0;
	logic sys_rst = 1'b1;
	logic [13:0] instr = 14'h0000;
	logic instr_valid = 1'b0;
	logic instr_ready, retire, zero_flag, carry_flag, reg_rd_en, reg_wr_en;
	logic [14:0] pc;
	logic [14:0] ep = 15'h0000;
	logic [7:0] acc, reg_rd_data, reg_wr_data;
	logic [6:0] reg_addr;
	int err_count = 0;
	int n_checks = 0;
	lsbb_exec dut (
		.clock(clock),
		.sys_rst(sys_rst),
		.instr(instr),
		.instr_valid(instr_valid),
		.instr_ready(instr_ready),
		.retire(retire),
		.pc(pc),
		.acc(acc),
		.zero_flag(zero_flag),
		.carry_flag(carry_flag),
		.reg_addr(reg_addr),
		.reg_rd_en(reg_rd_en),
		.reg_rd_data(reg_rd_data),
		.reg_wr_en(reg_wr_en),
		.reg_wr_data(reg_wr_data)
	);
	lsbb_regfile rf (
		.clock(clock),
		.reg_rd_en(reg_rd_en),
		.reg_addr(reg_addr),
		.reg_wr_en(reg_wr_en),
		.reg_wr_data(reg_wr_data),
		.reg_rd_data(reg_rd_data)
	);
	// 25 MHz
	always #20 clock = ~clock;
	task automatic chk(input string nm, input logic [14:0] x, g);
		n_checks++;
		if (g !== x)
		begin
			err_count++;
			$display("FAIL %s exp %h got %h", nm, x, g);
		end
	endtask : chk
	// Offer one word; retire must land on its own cycle only
	task automatic run(input logic [13:0] w, input int lat, input int o);
		while (instr_ready !== 1'b1)
			@(negedge clock);
		@(posedge clock);
		instr <= w;
		instr_valid <= 1'b1;
		@(posedge clock);
		instr_valid <= 1'b0;
		ep = ep + 15'h0001 + 15'(o);
		for (int i = 1; i <= 4; i++)
		begin
			@(negedge clock);
			chk("retire", i == lat, retire);
		end
		chk("pc", ep, pc);
	endtask : run
	task automatic tally_and_finish;
		$display("checks %0d errors %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : tally_and_finish
	// Hang guard, far beyond the roughly 150 cycles needed
	initial
	begin
		repeat (3000) @(posedge clock);
		err_count++;
		tally_and_finish();
	end
	initial
	begin
		rf.mem[5] = 8'h96;
		rf.mem[6] = 8'h81;
		rf.mem[7] = 8'h3C;
		rf.mem[8] = 8'h34;
		rf.mem[9] = 8'hFF;
		rf.mem[10] = 8'h00;
		rf.mem[11] = 8'h97;
		repeat (10) @(posedge clock);
		sys_rst <= 1'b0;
		run({lsbb_pkg::OPC_ASR, 1'b0, 7'h05}, 3, 0);
		chk("acc", 8'hCB, acc);
		chk("mem5", 8'h96, rf.mem[5]);
		run({lsbb_pkg::OPC_ASR, 1'b1, 7'h06}, 3, 0);
		chk("mem6", 8'hC0, rf.mem[6]);
		chk("carry", 1'b1, carry_flag);
		run({lsbb_pkg::OPC_AND_REG, 1'b1, 7'h07}, 3, 0);
		chk("mem7", 8'h08, rf.mem[7]);
		chk("acc", 8'hCB, acc);
		run({lsbb_pkg::OPC_AND_REG, 1'b0, 7'h08}, 3, 0);
		chk("acc", 8'h00, acc);
		chk("zero", 1'b1, zero_flag);
		chk("mem8", 8'h34, rf.mem[8]);
		run({lsbb_pkg::OPC_ASR, 1'b0, 7'h0B}, 3, 0);
		run({lsbb_pkg::OPC_AND_LIT, 8'h0F}, 1, 0);
		chk("acc", 8'h0B, acc);
		run({lsbb_pkg::OPC_AND_LIT, 8'h30}, 1, 0);
		chk("zero", 1'b1, zero_flag);
		chk("carry", 1'b1, carry_flag);
		run(14'h0000, 1, 0);
		chk("acc", 8'h00, acc);
		// Walk every bit position in both directions
		for (int b = 0; b < 8; b++)
		begin
			run({lsbb_pkg::OPC_CLR_BIT, 3'(b), 7'h09}, 3, 0);
			run({lsbb_pkg::OPC_SET_BIT, 3'(b), 7'h0A}, 3, 0);
			chk("clr", 8'(8'hFE << b), rf.mem[9]);
			chk("set", 8'(8'hFF >> (7 - b)), rf.mem[10]);
		end
		chk("zero", 1'b1, zero_flag);
		chk("carry", 1'b1, carry_flag);
		run({lsbb_pkg::OPC_PC_OFS, 9'h100}, 2, 15'h7F00);
		run({lsbb_pkg::OPC_PC_OFS, 9'h0FF}, 2, 15'h00FF);
		run({lsbb_pkg::OPC_ASR, 1'b0, 7'h0B}, 3, 0);
		run(lsbb_pkg::INSTR_PC_ACC, 2, 15'h00CB);
		chk("zero", 1'b0, zero_flag);
		chk("acc", 8'hCB, acc);
		tally_and_finish();
	end
endmodule : test_logic_shift_bit_branch_exec
bind lsbb_exec lsbb_props u_props (
	.clock(clock),
	.sys_rst(sys_rst),
	.instr(instr),
	.instr_valid(instr_valid),
	.instr_ready(instr_ready),
	.retire(retire),
	.pc(pc),
	.acc(acc),
	.zero_flag(zero_flag),
	.carry_flag(carry_flag),
	.reg_addr(reg_addr),
	.reg_rd_en(reg_rd_en),
	.reg_rd_data(reg_rd_data),
	.reg_wr_en(reg_wr_en),
	.reg_wr_data(reg_wr_data)
);
`default_nettype wire
